// >>> tcwd_defs.vh
// Constants for the terminal control register and wiper tap decode
`ifndef TCWD_DEFS_VH
`define TCWD_DEFS_VH
`define TCWD_TERMINAL_SWITCH_REGISTER_ADDR 4'h4
`define TCWD_WIPER_ADDR 4'h0
`define TCWD_TERMINAL_SWITCH_REGISTER_RESET 8'hFF
`define TCWD_TERMINAL_SWITCH_REGISTER_BITS_RESET 4'hF
`define TCWD_UPPER_FIXED 4'hF
`define TCWD_BIT_HW 3
`define TCWD_BIT_A 2
`define TCWD_BIT_W 1
`define TCWD_BIT_B 0
`define TCWD_WIPER_RESET_8 8'h7F
`define TCWD_WIPER_RESET_7 8'h3F
`define TCWD_FULL_8 8'hFF
`define TCWD_FULL_7 8'h7F
`endif

// >>> tcwd_tap_decode.v
// One-hot tap selection decode of the wiper code
`timescale 1ns/1ns
module tcwd_tap_decode
(
    input wire clk_sys_in,
    input wire arst_n_in,
    input wire mode_7bit_in,
    input wire [7:0] wiper_code_in,
    output reg [255:0] tap_sel_out,
    output reg zero_scale_out,
    output reg full_scale_out
);
`include "tcwd_defs.vh"

    wire [7:0] code_eff;
    wire [7:0] full_code;

    // The 7-bit part ignores the top code bit so taps stay within 0..127
    assign code_eff = mode_7bit_in ? {1'b0, wiper_code_in[6:0]} : wiper_code_in;
    assign full_code = mode_7bit_in ? `TCWD_FULL_7 : `TCWD_FULL_8;

    genvar gi;
    generate
        for (gi = 0; gi < 256; gi = gi + 1)
        begin : g_tap
            always @(posedge clk_sys_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                    tap_sel_out[gi] <= 1'b0;
                else
                    tap_sel_out[gi] <= (code_eff == gi);
            end
        end
    endgenerate

    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            zero_scale_out <= 1'b0;
            full_scale_out <= 1'b0;
        end
        else
        begin
            zero_scale_out <= (code_eff == 8'h00);
            full_scale_out <= (code_eff == full_code);
        end
    end
endmodule

// >>> tcwd_terminal_control.v
// Terminal connection control register, shutdown logic and wiper register
`timescale 1ns/1ns
// Behaviour
// - Written terminal control takes effect only after the serial command completes.
// - Power-on or brown-out reset loads the terminal control register with FFh.
// - Bits 7 to 4 always read one and ignore writes.
// - Bit 3 clear forces the hardware shutdown arrangement; set means no forcing.
// - Bit 2 connects terminal A when one, disconnects when zero.
// - Bit 1 connects the wiper pin when one, disconnects when zero.
// - Bit 0 connects terminal B when one, disconnects when zero.
// - Terminal control writes never change the stored wiper value.
// - Shutdown pin asserted overrides the bits; release returns control to them.
// - Shutdown pin never alters the stored terminal control value.
// - 8-bit variant decodes 256 taps: 00h B, 7Fh mid, FFh A.
// - 7-bit variant decodes 128 taps: 00h B, 3Fh mid, 7Fh A.
// - Shutdown opens terminal A and ties wiper to terminal B.
// - Forced shutdown ignores A, W, B bits but keeps their stored values.
module tcwd_terminal_control
(
    input wire clk_sys_in,
    input wire arst_n_in,
    input wire mode_7bit_in,
    input wire shutdown_pin_n_in,
    input wire wiper_latch_n_in,
    input wire wr_en_in,
    input wire [3:0] wr_addr_in,
    input wire [7:0] wr_data_in,
    input wire cmd_done_in,
    input wire [3:0] rd_addr_in,
    output reg [7:0] rd_data_out,
    output reg rd_err_out,
    output wire [7:0] terminal_connect_control_out,
    output wire [7:0] wiper_reg_out,
    output reg term_a_switch_out,
    output reg wiper_switch_out,
    output reg term_b_switch_out,
    output reg wiper_to_b_out,
    output reg shutdown_active_out,
    output wire [255:0] tap_sel_out,
    output wire zero_scale_out,
    output wire full_scale_out
);
`include "tcwd_defs.vh"

    // Stored register holds only the four writable bits
    reg [3:0] terminal_switch_register_q;
    reg [3:0] terminal_switch_register_pend_q;
    reg pend_terminal_switch_register_q;
    reg [7:0] wiper_q;
    reg [7:0] wiper_pend_q;
    reg pend_wiper_q;
    reg [7:0] wiper_live_q;
    reg shutdown_pin_n_meta_q;
    reg shutdown_pin_n_sync_q;
    reg wlat_meta_q;
    reg wlat_sync_q;
    reg mode_meta_q;
    reg mode_sync_q;
    reg [3:0] terminal_switch_register_d;
    reg [7:0] wiper_d;

    function [7:0] tcwd_wiper_reset;
        input is_7bit;
        begin
            tcwd_wiper_reset = is_7bit ? `TCWD_WIPER_RESET_7 : `TCWD_WIPER_RESET_8;
        end
    endfunction

    function addr_valid;
        input [3:0] addr;
        begin
            addr_valid = (addr == `TCWD_TERMINAL_SWITCH_REGISTER_ADDR) || (addr == `TCWD_WIPER_ADDR);
        end
    endfunction

    // Pins come from outside the clock domain
    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            shutdown_pin_n_meta_q <= 1'b1;
            shutdown_pin_n_sync_q <= 1'b1;
            wlat_meta_q <= 1'b0;
            wlat_sync_q <= 1'b0;
            mode_meta_q <= 1'b0;
            mode_sync_q <= 1'b0;
        end
        else
        begin
            shutdown_pin_n_meta_q <= shutdown_pin_n_in;
            shutdown_pin_n_sync_q <= shutdown_pin_n_meta_q;
            wlat_meta_q <= wiper_latch_n_in;
            wlat_sync_q <= wlat_meta_q;
            mode_meta_q <= mode_7bit_in;
            mode_sync_q <= mode_meta_q;
        end
    end

    assign terminal_connect_control_out = {`TCWD_UPPER_FIXED, terminal_switch_register_q};
    assign wiper_reg_out = wiper_q;

    always @*
    begin
        terminal_switch_register_d = terminal_switch_register_q;
        wiper_d = wiper_q;
        if (cmd_done_in && pend_terminal_switch_register_q)
            terminal_switch_register_d = terminal_switch_register_pend_q;
        if (cmd_done_in && pend_wiper_q)
            wiper_d = wiper_pend_q;
    end

    // Writes are staged and committed when the command finishes
    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            terminal_switch_register_q <= `TCWD_TERMINAL_SWITCH_REGISTER_BITS_RESET;
            terminal_switch_register_pend_q <= `TCWD_TERMINAL_SWITCH_REGISTER_BITS_RESET;
            pend_terminal_switch_register_q <= 1'b0;
            wiper_q <= `TCWD_WIPER_RESET_8;
            wiper_pend_q <= `TCWD_WIPER_RESET_8;
            pend_wiper_q <= 1'b0;
        end
        else
        begin
            terminal_switch_register_q <= terminal_switch_register_d;
            wiper_q <= wiper_d;
            if (cmd_done_in)
            begin
                pend_terminal_switch_register_q <= 1'b0;
                pend_wiper_q <= 1'b0;
            end
            if (wr_en_in && (wr_addr_in == `TCWD_TERMINAL_SWITCH_REGISTER_ADDR))
            begin
                terminal_switch_register_pend_q <= wr_data_in[3:0];
                pend_terminal_switch_register_q <= 1'b1;
            end
            if (wr_en_in && (wr_addr_in == `TCWD_WIPER_ADDR))
            begin
                wiper_pend_q <= wr_data_in;
                pend_wiper_q <= 1'b1;
            end
        end
    end

    // Wiper register resets to 7Fh in both variants; the variant value caught once after release never reaches the taps
    reg mode_seen_q;
    reg [7:0] wiper_base_q;
    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            mode_seen_q <= 1'b0;
            wiper_base_q <= `TCWD_WIPER_RESET_8;
            wiper_live_q <= `TCWD_WIPER_RESET_8;
        end
        else
        begin
            mode_seen_q <= 1'b1;
            if (!mode_seen_q)
                wiper_base_q <= tcwd_wiper_reset(mode_sync_q);
            // Wiper latch high holds the previous tap
            if (!wlat_sync_q)
                wiper_live_q <= (pend_wiper_q || wiper_q != `TCWD_WIPER_RESET_8 || mode_seen_q)
                    ? wiper_q : wiper_base_q;
        end
    end

    // Shutdown and terminal switch outputs
    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            shutdown_active_out <= 1'b0;
            term_a_switch_out <= 1'b1;
            wiper_switch_out <= 1'b1;
            term_b_switch_out <= 1'b1;
            wiper_to_b_out <= 1'b0;
        end
        else
        begin
            shutdown_active_out <= !shutdown_pin_n_sync_q || !terminal_switch_register_q[`TCWD_BIT_HW];
            if (!shutdown_pin_n_sync_q || !terminal_switch_register_q[`TCWD_BIT_HW])
            begin
                term_a_switch_out <= 1'b0;
                wiper_switch_out <= 1'b1;
                term_b_switch_out <= 1'b1;
                wiper_to_b_out <= 1'b1;
            end
            else
            begin
                term_a_switch_out <= terminal_switch_register_q[`TCWD_BIT_A];
                wiper_switch_out <= terminal_switch_register_q[`TCWD_BIT_W];
                term_b_switch_out <= terminal_switch_register_q[`TCWD_BIT_B];
                wiper_to_b_out <= 1'b0;
            end
        end
    end

    // Read port; unmapped addresses return zero with an error flag
    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rd_data_out <= 8'h00;
            rd_err_out <= 1'b0;
        end
        else
        begin
            rd_err_out <= !addr_valid(rd_addr_in);
            if (rd_addr_in == `TCWD_TERMINAL_SWITCH_REGISTER_ADDR)
                rd_data_out <= {`TCWD_UPPER_FIXED, terminal_switch_register_q};
            else if (rd_addr_in == `TCWD_WIPER_ADDR)
                rd_data_out <= wiper_q;
            else
                rd_data_out <= 8'h00;
        end
    end

    tcwd_tap_decode u_decode
    (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .mode_7bit_in(mode_sync_q),
        .wiper_code_in(wiper_live_q),
        .tap_sel_out(tap_sel_out),
        .zero_scale_out(zero_scale_out),
        .full_scale_out(full_scale_out)
    );
endmodule

// >>> tcwd_tc_chk_asserts.sv
// Port checks for the terminal control block
`timescale 1ns/1ns
module tcwd_tc_chk
(
    input wire clk_sys_in,
    input wire arst_n_in,
    input wire shutdown_pin_n_in,
    input wire cmd_done_in,
    input wire [7:0] terminal_connect_control_out,
    input wire [7:0] wiper_reg_out,
    input wire term_a_switch_out,
    input wire wiper_switch_out,
    input wire term_b_switch_out,
    input wire wiper_to_b_out,
    input wire shutdown_active_out
);
    wire [7:0] r = terminal_connect_control_out;
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);
    upper_fixed_a: assert property (r[7:4] == 4'hF)
        else $error("upper bits cleared");
    hw_force_a: assert property (!r[3] |=> shutdown_active_out)
        else $error("forced shutdown missing");
    sd_shape_a: assert property (shutdown_active_out |->
        !term_a_switch_out && wiper_to_b_out) else $error("shutdown shape wrong");
    a_follow_a: assert property (!shutdown_active_out |->
        term_a_switch_out == $past(r[2])) else $error("terminal a switch wrong");
    w_follow_a: assert property (!shutdown_active_out |->
        wiper_switch_out == $past(r[1])) else $error("wiper switch wrong");
    b_follow_a: assert property (!shutdown_active_out |->
        term_b_switch_out == $past(r[0])) else $error("terminal b switch wrong");
    pin_force_a: assert property (!shutdown_pin_n_in [*3] |=> shutdown_active_out)
        else $error("pin shutdown missing");
    tcc_commit_a: assert property ($changed(r) |->
        $past(cmd_done_in) || $past(cmd_done_in, 2)) else $error("register moved uncommitted");
    wiper_keep_a: assert property ($changed(wiper_reg_out) |->
        $past(cmd_done_in) || $past(cmd_done_in, 2)) else $error("wiper moved uncommitted");
    cover property ($rose(shutdown_active_out));
    cover property ($fell(shutdown_pin_n_in));
    cover property ($changed(wiper_reg_out));
endmodule
bind tcwd_terminal_control tcwd_tc_chk u_chk (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .shutdown_pin_n_in(shutdown_pin_n_in), .cmd_done_in(cmd_done_in),
    .terminal_connect_control_out(terminal_connect_control_out), .wiper_reg_out(wiper_reg_out),
    .term_a_switch_out(term_a_switch_out), .wiper_switch_out(wiper_switch_out),
    .term_b_switch_out(term_b_switch_out), .wiper_to_b_out(wiper_to_b_out),
    .shutdown_active_out(shutdown_active_out));

// >>> tcwd_host_model.sv
// Host side that stages and commits register writes
`timescale 1ns/1ns
module tcwd_host_model
(
    input wire clk_sys_in,
    output reg wr_en_out = 1'b0,
    output reg [3:0] wr_addr_out = 4'hB,
    output reg [7:0] wr_data_out = 8'hA5,
    output reg cmd_done_out = 1'b0
);
    task stage(input [3:0] a, input [7:0] d);
    begin
        wr_en_out <= 1'b1;
        wr_addr_out <= a;
        wr_data_out <= d;
        @(posedge clk_sys_in);
        wr_en_out <= 1'b0;
        wr_addr_out <= ~a;
        wr_data_out <= ~d;
    end
    endtask
    // Caller may delay this to mimic a slow command end
    task commit;
    begin
        cmd_done_out <= 1'b1;
        @(posedge clk_sys_in);
        cmd_done_out <= 1'b0;
    end
    endtask
endmodule

// >>> tcwd_terminal_control_tb_top.sv
// Testbench for the terminal control block
`timescale 1ns/1ns
module tcwd_terminal_control_tb_top;
    reg clk_sys_in = 1'b0;
    reg arst_n_in = 1'b0;
    reg m7 = 1'b0;
    reg pin_n = 1'b1;
    reg [3:0] ra = 4'h4;
    wire we, dn, sa, sw, sb, wb, sd, re, zs, fs;
    wire [3:0] wa;
    wire [7:0] wd, tcc, wip, rd;
    wire [255:0] tap;
    wire [7:0] sv = {3'h0, sa, sw, sb, wb, sd};
    integer miscompares = 0;
    integer total_checks = 0;
    integer i;
    reg [12:0] rows [0:6];
    always #20 clk_sys_in = ~clk_sys_in;
    tcwd_host_model u_host (.clk_sys_in(clk_sys_in), .wr_en_out(we), .wr_addr_out(wa),
        .wr_data_out(wd), .cmd_done_out(dn));
    tcwd_terminal_control uut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .mode_7bit_in(m7), .shutdown_pin_n_in(pin_n), .wiper_latch_n_in(1'b0),
        .wr_en_in(we), .wr_addr_in(wa), .wr_data_in(wd), .cmd_done_in(dn), .rd_addr_in(ra),
        .rd_data_out(rd), .rd_err_out(re), .terminal_connect_control_out(tcc),
        .wiper_reg_out(wip), .term_a_switch_out(sa), .wiper_switch_out(sw),
        .term_b_switch_out(sb), .wiper_to_b_out(wb), .shutdown_active_out(sd),
        .tap_sel_out(tap), .zero_scale_out(zs), .full_scale_out(fs));
    task chk(input [7:0] got, input [7:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task end_sim;
    begin
        if (miscompares == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    task wr(input [3:0] a, input [7:0] d);
    begin
        @(posedge clk_sys_in);
        u_host.stage(a, d);
        u_host.commit;
        repeat (5) @(posedge clk_sys_in);
        #1;
    end
    endtask
    task tp(input [7:0] c, input [1:0] fz);
    begin
        wr(4'h0, c);
        chk({6'h0, fs, zs}, {6'h0, fz});
        chk({7'h0, tap[c]}, 8'h01);
        chk(tcc, 8'hFF);
    end
    endtask
    initial
    begin
        #100000;
        miscompares = miscompares + 1;
        end_sim;
    end
    initial
    begin
        rows[0] = {8'h08, 5'b00000};
        rows[1] = {8'h0C, 5'b10000};
        rows[2] = {8'h0A, 5'b01000};
        rows[3] = {8'h09, 5'b00100};
        rows[4] = {8'h00, 5'b01111};
        rows[5] = {8'hF7, 5'b01111};
        rows[6] = {8'h0F, 5'b11100};
        repeat (8) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        #1;
        chk(tcc, 8'hFF);
        chk(sv, 8'h1C);
        for (i = 0; i < 7; i = i + 1)
        begin
            wr(4'h4, rows[i][12:5]);
            chk(tcc, {4'hF, rows[i][8:5]});
            chk(sv, {3'h0, rows[i][4:0]});
            chk(wip, 8'h7F);
        end
        @(posedge clk_sys_in);
        u_host.stage(4'h4, 8'h03);
        repeat (4) @(posedge clk_sys_in);
        #1;
        chk(tcc, 8'hFF);
        @(posedge clk_sys_in);
        u_host.commit;
        repeat (4) @(posedge clk_sys_in);
        #1;
        chk(sv, 8'h0F);
        wr(4'h4, 8'h0F);
        pin_n <= 1'b0;
        repeat (5) @(posedge clk_sys_in);
        #1;
        chk(sv, 8'h0F);
        chk(tcc, 8'hFF);
        wr(4'h1, 8'h00);
        chk(rd, 8'hFF);
        pin_n <= 1'b1;
        ra <= 4'h2;
        repeat (5) @(posedge clk_sys_in);
        #1;
        chk(sv, 8'h1C);
        chk({7'h0, re}, 8'h01);
        tp(8'hFF, 2'b10);
        tp(8'h7F, 2'b00);
        m7 <= 1'b1;
        tp(8'h7F, 2'b10);
        tp(8'h3F, 2'b00);
        tp(8'h00, 2'b01);
        end_sim;
    end
endmodule
